// ---- shared/pwr_pkg.sv ----
// power reduction control package: constants, state and carrier types
// assumes one core clock; no software-reachable register bus
package pwr_pkg;
    localparam int          PCR_WIDTH      = 8;
    localparam int          IDLE_BIT       = 0;
    localparam int          PD_BIT         = 1;
    localparam logic [7:0]  PCR_RESET      = 8'h00;
    localparam int          OSC_START_MS   = 10;
    localparam int          CLK_MHZ        = 125;
    // least hold of reset, rounded up to whole cycles
    localparam int          OSC_START_CYC  = OSC_START_MS * 1000 * CLK_MHZ;

    typedef enum logic [2:0] {
        RUN  = 3'b001,
        IDLE = 3'b010,
        DOWN = 3'b100
    } pmode_t;

    // port latch contents from the core
    typedef struct packed {
        logic [7:0] p0;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
        logic [7:0] p4;
    } port_latch_t;

    // gating outputs to the peripherals
    typedef struct packed {
        logic cpu_run;
        logic osc_run;
        logic capture_timer_run;
        logic capture_timer_clear;
        logic pulse_reset;
        logic conv_abort;
        logic gen_timers_run;
        logic watchdog_run;
        logic serial_run;
        logic ext_int_run;
    } gate_t;
endpackage

// ---- rtl/idle_powerdown_control.sv ----
// idle and power-down sequencing for the 8-bit core
// assumes core write strobe, port latches and external-fetch flag on SYS_CLK
`timescale 1ns/1ps
`default_nettype none
module idle_powerdown_control
    import pwr_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // power control register write from the core
    input  wire logic        PCR_WR,
    input  wire logic        PCR_BYTE,
    input  wire logic [7:0]  PCR_WDATA,
    output logic [7:0]       PCR_RDATA,
    // pins and core status
    input  wire logic        PERMIT_PIN,
    input  wire logic        EXT_FETCH,
    input  wire logic        INT_WAKE,
    input  wire port_latch_t PORT_LATCH,
    input  wire logic        CORE_ALE,
    input  wire logic        CORE_PSEN,
    input  wire logic [7:0]  CORE_P0,
    input  wire logic [7:0]  CORE_P2,
    input  wire logic [7:0]  CORE_P0_OE,
    input  wire logic        CORE_PULSE0,
    input  wire logic        CORE_PULSE1,
    // gated pin outputs
    output logic             ALE_OUT,
    output logic             PSEN_OUT,
    output logic [7:0]       P0_OUT,
    output logic [7:0]       P0_OE,
    output logic [7:0]       P2_OUT,
    output logic [7:0]       STRONG_PULLUP,
    output logic             PULSE0_OUT,
    output logic             PULSE1_OUT,
    // peripheral gating
    output gate_t            GATE,
    output pmode_t           MODE
);
    logic       permit_meta;
    logic       permit;
    logic       wake_meta;
    logic       wake;
    logic [7:0] pcr;
    pmode_t     mode;
    logic       ext_at_down;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            permit_meta <= 1'b0;
            permit      <= 1'b0;
            wake_meta   <= 1'b0;
            wake        <= 1'b0;
        end else begin
            permit_meta <= PERMIT_PIN;
            permit      <= permit_meta;
            wake_meta   <= INT_WAKE;
            wake        <= wake_meta;
        end
    end

    // control register: byte writes only; power-down bit gated by permit
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pcr <= PCR_RESET;
        end else if (mode == RUN && PCR_WR && PCR_BYTE) begin
            pcr          <= PCR_WDATA;
            pcr[PD_BIT]  <= PCR_WDATA[PD_BIT] & permit;
        end else if (mode == IDLE && wake) begin
            pcr[IDLE_BIT] <= 1'b0;
        end
    end

    // mode follows the register; power-down is left only by reset
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            mode <= RUN;
        end else begin
            unique case (mode)
                RUN: begin
                    if (PCR_WR && PCR_BYTE && PCR_WDATA[PD_BIT] && permit) begin
                        mode <= DOWN;
                    end else if (PCR_WR && PCR_BYTE && PCR_WDATA[IDLE_BIT]) begin
                        mode <= IDLE;
                    end
                end
                IDLE: begin
                    if (wake) begin
                        mode <= RUN;
                    end
                end
                DOWN: begin
                    mode <= DOWN;
                end
                default: begin
                    mode <= RUN;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ext_at_down <= 1'b0;
        end else if (mode == RUN) begin
            ext_at_down <= EXT_FETCH;
        end
    end

    always_comb begin
        GATE.cpu_run             = (mode == RUN);
        GATE.osc_run             = (mode != DOWN);
        GATE.capture_timer_run   = (mode == RUN);
        GATE.capture_timer_clear = (mode == IDLE);
        GATE.pulse_reset         = (mode != RUN);
        GATE.conv_abort          = (mode != RUN);
        GATE.gen_timers_run      = (mode != DOWN);
        GATE.watchdog_run        = (mode != DOWN);
        GATE.serial_run          = (mode != DOWN);
        GATE.ext_int_run         = (mode != DOWN);
    end

    // pin view by mode
    always_comb begin
        ALE_OUT       = CORE_ALE;
        PSEN_OUT      = CORE_PSEN;
        P0_OUT        = CORE_P0;
        P0_OE         = CORE_P0_OE;
        P2_OUT        = CORE_P2;
        STRONG_PULLUP = 8'h00;
        PULSE0_OUT    = CORE_PULSE0;
        PULSE1_OUT    = CORE_PULSE1;
        unique case (mode)
            RUN: begin
            end
            IDLE: begin
                ALE_OUT    = 1'b1;
                PSEN_OUT   = 1'b1;
                P0_OUT     = PORT_LATCH.p0;
                P0_OE      = EXT_FETCH ? 8'h00 : 8'hff;
                P2_OUT     = PORT_LATCH.p2;
                PULSE0_OUT = 1'b1;
                PULSE1_OUT = 1'b1;
            end
            DOWN: begin
                ALE_OUT       = 1'b0;
                PSEN_OUT      = 1'b0;
                P0_OUT        = PORT_LATCH.p0;
                P0_OE         = 8'hff;
                P2_OUT        = PORT_LATCH.p2;
                STRONG_PULLUP = PORT_LATCH.p2;
                PULSE0_OUT    = 1'b1;
                PULSE1_OUT    = 1'b1;
            end
            default: begin
            end
        endcase
    end

    assign PCR_RDATA = pcr;
    assign MODE      = mode;

    // a byte write that carries a permitted power-down bit
    sequence pd_write_s;
        PCR_WR && PCR_BYTE && PCR_WDATA[PD_BIT] && permit && mode == RUN;
    endsequence

    // a byte write that asks for idle and not for a permitted power-down
    sequence idle_write_s;
        PCR_WR && PCR_BYTE && PCR_WDATA[IDLE_BIT] && !(PCR_WDATA[PD_BIT] && permit)
        && mode == RUN;
    endsequence

    sequence down_entered_s;
        mode == DOWN && !GATE.osc_run && !GATE.cpu_run;
    endsequence

    sequence idle_entered_s;
        mode == IDLE && pcr[IDLE_BIT] && !GATE.cpu_run;
    endsequence

    // entry into the two modes, only by a byte write
    pd_entry_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        pd_write_s |=> down_entered_s)
        else $error("power-down not entered");
    idle_entry_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        idle_write_s |=> idle_entered_s)
        else $error("idle not entered");
    run_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (mode == RUN && !(PCR_WR && PCR_BYTE)) |=> mode == RUN)
        else $error("mode left run without a write");
    run_pins_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode == RUN |-> ALE_OUT == CORE_ALE && PSEN_OUT == CORE_PSEN && P0_OUT == CORE_P0
        && P0_OE == CORE_P0_OE && P2_OUT == CORE_P2 && STRONG_PULLUP == 8'h00)
        else $error("run pins not passed through");
    pd_permit_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (mode == RUN && !permit) |=> mode != DOWN)
        else $error("power-down without permit");
    pd_bit_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (!permit && !pcr[PD_BIT]) |=> !pcr[PD_BIT])
        else $error("power-down bit set without permit");
    // a wake in idle may clear the idle bit in the same cycle, so only run is watched
    byte_only_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (mode == RUN && PCR_WR && !PCR_BYTE) |=> $stable(pcr))
        else $error("non-byte write took");

    // power-down holds everything until reset
    pd_sticky_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode == DOWN |=> mode == DOWN)
        else $error("power-down left without reset");
    pd_freeze_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode == DOWN |=> $stable(pcr))
        else $error("register changed in power-down");
    down_pins_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode == DOWN |-> !ALE_OUT && !PSEN_OUT && PULSE0_OUT && PULSE1_OUT
        && P0_OUT == PORT_LATCH.p0 && P0_OE == 8'hff)
        else $error("power-down pins wrong");
    down_p2_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (mode == DOWN && ext_at_down) |-> P2_OUT == PORT_LATCH.p2)
        else $error("high address port not restored");
    pullup_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode == DOWN |-> STRONG_PULLUP == PORT_LATCH.p2)
        else $error("strong pull-up not on latched ones");

    // idle gating, pins and wake
    idle_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode == IDLE |-> !GATE.cpu_run && GATE.capture_timer_clear && PULSE0_OUT
        && PULSE1_OUT && GATE.conv_abort)
        else $error("idle gating wrong");
    idle_keep_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode == IDLE |-> GATE.gen_timers_run && GATE.watchdog_run && GATE.serial_run
        && GATE.ext_int_run)
        else $error("idle stopped a live unit");
    idle_pins_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (mode == IDLE && EXT_FETCH) |-> ALE_OUT && PSEN_OUT && P0_OE == 8'h00
        && P2_OUT == PORT_LATCH.p2)
        else $error("idle pins wrong");
    idle_wake_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (mode == IDLE && wake) |=> mode == RUN && !pcr[IDLE_BIT])
        else $error("idle not ended by wake");
endmodule
`default_nettype wire

// ---- tb/test_idle_powerdown_control.sv ----
// self-checking bench for the idle and power-down sequencer
// assumes pwr_pkg is compiled first; the bench drives every core-side input itself
`timescale 1ns/1ps
`default_nettype none
module test_idle_powerdown_control;
    import pwr_pkg::*;
    logic        sys_clk;
    logic        rst;
    logic        pcr_wr;
    logic        pcr_byte;
    logic [7:0]  pcr_wdata;
    logic        permit;
    logic        ext_fetch;
    logic        int_wake;
    port_latch_t latch;
    logic [7:0]  pcr_rdata;
    logic [7:0]  p0_out;
    logic [7:0]  p0_oe;
    logic [7:0]  p2_out;
    logic [7:0]  strong_pullup;
    logic [7:0]  core_p2;
    logic        core_ale;
    logic        ale_out;
    logic        psen_out;
    logic        pulse0_out;
    logic        pulse1_out;
    gate_t       gate;
    pmode_t      mode;
    int          errors;
    int          comparisons;

    idle_powerdown_control u_idle_powerdown_control (
        .SYS_CLK(sys_clk), .RST(rst), .PCR_WR(pcr_wr), .PCR_BYTE(pcr_byte),
        .PCR_WDATA(pcr_wdata), .PCR_RDATA(pcr_rdata), .PERMIT_PIN(permit),
        .EXT_FETCH(ext_fetch), .INT_WAKE(int_wake), .PORT_LATCH(latch),
        .CORE_ALE(core_ale), .CORE_PSEN(1'b0), .CORE_P0(8'h3c), .CORE_P2(core_p2),
        .CORE_P0_OE(8'hff), .CORE_PULSE0(1'b0), .CORE_PULSE1(1'b0),
        .ALE_OUT(ale_out), .PSEN_OUT(psen_out), .P0_OUT(p0_out), .P0_OE(p0_oe),
        .P2_OUT(p2_out), .STRONG_PULLUP(strong_pullup), .PULSE0_OUT(pulse0_out),
        .PULSE1_OUT(pulse1_out), .GATE(gate), .MODE(mode));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one write strobe; outputs are settled when the task returns
    task automatic write_pcr(input logic whole, input logic [7:0] d);
        pcr_wr    = 1'b1;
        pcr_byte  = whole;
        pcr_wdata = d;
        cycles(1);
        pcr_wr    = 1'b0;
    endtask

    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic test_idle();
        int n;
        ext_fetch = 1'b1;
        write_pcr(1'b1, 8'h01);
        check({5'h0, mode}, {5'h0, IDLE});
        check(pcr_rdata, 8'h01);
        check({3'h0, gate.cpu_run, gate.capture_timer_run, gate.capture_timer_clear,
               gate.pulse_reset, gate.conv_abort}, 8'h07);
        check({6'h0, pulse0_out, pulse1_out}, 8'h03);
        check({3'h0, gate.gen_timers_run, gate.watchdog_run, gate.serial_run,
               gate.ext_int_run, gate.osc_run}, 8'h1f);
        check({6'h0, ale_out, psen_out}, 8'h03);
        check(p0_oe, 8'h00);
        check(p2_out, latch.p2);
        int_wake = 1'b1;
        n = 0;
        while (mode !== RUN && n < 10) begin
            cycles(1);
            n++;
        end
        if (n == 10) begin
            errors++;
            final_report();
        end
        check(pcr_rdata, 8'h00);
        check({7'h0, gate.cpu_run}, 8'h01);
        int_wake = 1'b0;
        ext_fetch = 1'b0;
        $display("test idle done");
    endtask

    task automatic test_refused();
        permit = 1'b0;
        cycles(3);
        write_pcr(1'b1, 8'h02);
        check({5'h0, mode}, {5'h0, RUN});
        check(pcr_rdata, 8'h00);
        cycles(1);
        write_pcr(1'b0, 8'h01);
        check(pcr_rdata, 8'h00);
        check({5'h0, mode}, {5'h0, RUN});
        $display("test refused done");
    endtask

    task automatic test_down();
        permit = 1'b1;
        ext_fetch = 1'b1;
        cycles(3);
        write_pcr(1'b1, 8'h03);
        check({5'h0, mode}, {5'h0, DOWN});
        check({6'h0, gate.osc_run, gate.cpu_run}, 8'h00);
        check({6'h0, ale_out, psen_out}, 8'h00);
        check({6'h0, pulse0_out, pulse1_out}, 8'h03);
        check(p0_out, latch.p0);
        check(p0_oe, 8'hff);
        check(p2_out, latch.p2);
        check(strong_pullup, latch.p2);
        check(pcr_rdata, 8'h03);
        int_wake = 1'b1;
        cycles(5);
        write_pcr(1'b1, 8'h00);
        check({5'h0, mode}, {5'h0, DOWN});
        int_wake = 1'b0;
        // a board holds reset for OSC_START_CYC; kept short to bound the run
        rst = 1'b1;
        cycles(2);
        rst = 1'b0;
        check({5'h0, mode}, {5'h0, RUN});
        check(pcr_rdata, 8'h00);
        check(p2_out, core_p2);
        $display("test power-down done");
    endtask

    initial begin
        errors = 0;
        comparisons = 0;
        rst = 1'b1;
        pcr_wr = 1'b0;
        pcr_byte = 1'b0;
        pcr_wdata = 8'h00;
        permit = 1'b1;
        ext_fetch = 1'b0;
        int_wake = 1'b0;
        core_ale = 1'b1;
        core_p2 = 8'hc3;
        latch = {8'h5a, 8'h11, 8'ha5, 8'h22, 8'h33};
        cycles(6);
        rst = 1'b0;
        cycles(3);
        check({5'h0, mode}, {5'h0, RUN});
        check({7'h0, ale_out}, {7'h0, core_ale});
        check(p2_out, core_p2);
        check(strong_pullup, 8'h00);
        test_idle();
        test_refused();
        test_down();
        final_report();
    end
endmodule
`default_nettype wire
